// ### rtl/dpll_xient_pkg.sv
// Summary of operation
// - Software enable for hitless switching
// - Trigger on ref change or holdover exit
// - Temporary holdover without holdover alarm
// - Measured phase offset loaded as zero
// - Track reference, keep captured offset
// - Two hitless types, nominal frequency dependence
// - Type 2 satellite shifts may accumulate
// - Only phase compensated, frequency pull-in allowed
// - Per-channel enabled phase slope limiter
// - Slope 1 ns/s to 65.536 us/s
// - Unlimited setting plus telecom limit values
// - Frequency deviation clamped to maximum offset
// - Four fast-lock methods, phase snap excludes pull-in
// - Each method enabled, acquire or recover
// - Priority: freq snap, phase snap, pull-in, wide
// - Frequency snap writes divider, optional slope
// - Phase snap jumps; pull-in opens loop
// - Wide mode relaxes limits until lock
// - Acquire-only max bandwidth for programmed ms
// - Non-revertive default, switch on invalid
package dpll_xient_pkg;

  localparam logic [7:0] ctrl_off      = 8'h00;
  localparam logic [7:0] psl_off       = 8'h04;
  localparam logic [7:0] max_freq_off  = 8'h08;
  localparam logic [7:0] fl_cfg_off    = 8'h0c;
  localparam logic [7:0] fl_psl_off    = 8'h10;
  localparam logic [7:0] fsl_off       = 8'h14;
  localparam logic [7:0] preacq_off    = 8'h18;
  localparam logic [7:0] status_off    = 8'h1c;
  localparam logic [7:0] zero_off      = 8'h20;

  // Control bits
  localparam int ctrl_hs_en   = 0;
  localparam int ctrl_hs_type = 1;
  localparam int ctrl_psl_en  = 2;
  localparam int ctrl_fsl_en  = 3;
  localparam int ctrl_pre_en  = 4;
  localparam int ctrl_revert  = 5;

  localparam logic [31:0] ctrl_rst     = 32'h0000_0000;
  localparam logic [15:0] psl_rst      = 16'h0000;
  localparam logic [31:0] max_freq_rst = 32'h7fff_ffff;
  localparam logic [7:0]  fl_cfg_rst   = 8'h00;
  localparam logic [15:0] fl_psl_rst   = 16'hffff;
  localparam logic [31:0] fsl_rst      = 32'h0000_0001;
  localparam logic [15:0] preacq_rst   = 16'h0000;

  localparam int clk_period_ps = 5000;
  localparam int tick_ms       = 1;
  localparam int tick_cycles   = tick_ms * 1000000000 / clk_period_ps;

  typedef enum logic [2:0] {
    st_acquire = 3'b000,
    st_locked  = 3'b001,
    st_hold    = 3'b010,
    st_hs_hold = 3'b011,
    st_preacq  = 3'b100
  } state_type;

endpackage

// ### rtl/dpll_switch_transient_control.sv
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module dpll_switch_transient_control #(
  parameter int tick_cycles = dpll_xient_pkg::tick_cycles
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Reference selection and measurement
  input  wire logic [3:0]  ref_sel,
  input  wire logic        ref_valid,
  input  wire logic        dpll_locked,
  input  wire logic [31:0] phase_meas,
  input  wire logic        phase_meas_valid,
  input  wire logic [31:0] freq_meas,
  input  wire logic        freq_meas_valid,
  input  wire logic [31:0] frac_residual,
  // Loop filter side
  input  wire logic [31:0] phase_loop,
  input  wire logic [31:0] freq_loop,
  output logic [31:0]      phase_zero_q,
  output logic [31:0]      phase_cmd_q,
  output logic             loop_open_q,
  output logic             bw_max_q,
  output logic             bw_wide_q,
  output logic             meas_req_q,
  // Steerable divider and status
  output logic [31:0]      freq_cmd_q,
  output logic             holdover_q,
  output logic             holdover_alarm_q,
  output logic             revertive_q
);

  function automatic logic [31:0] step(input logic [31:0] cur,
                                       input logic [31:0] tgt,
                                       input logic [31:0] lim);
    logic signed [32:0] d;
    d = $signed({tgt[31], tgt}) - $signed({cur[31], cur});
    if (d > $signed({1'b0, lim}))
      step = cur + lim;
    else if (d < -$signed({1'b0, lim}))
      step = cur - lim;
    else
      step = tgt;
  endfunction
  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] m);
    if ($signed(v) > $signed(m))
      clamp = m;
    else if ($signed(v) < -$signed(m))
      clamp = -m;
    else
      clamp = v;
  endfunction

  logic [31:0]               ctrl_q;
  logic [15:0]               psl_q;
  logic [31:0]               max_freq_q;
  logic [7:0]                fl_cfg_q;
  logic [15:0]               fl_psl_q;
  logic [31:0]               fsl_q;
  logic [15:0]               preacq_q;
  dpll_xient_pkg::state_type state_q;
  logic                      rec_q;
  logic [3:0]                done_q;
  logic                      pre_done_q;
  logic [3:0]                last_ref_q;
  logic                      snap_on_q;
  logic [31:0]               snap_tgt_q;
  logic                      ol_on_q;
  logic [31:0]               ol_tgt_q;
  logic [31:0]               tick_cnt_q;
  logic                      tick_q;
  logic [15:0]               ms_cnt_q;
  logic [15:0]               hs_count_q;
  logic                      aw_got_q;
  logic                      w_got_q;
  logic [7:0]                aw_q;
  logic [31:0]               wd_q;
  logic [3:0]                ws_q;
  logic        hs_en;
  logic [3:0]  app;
  logic [3:0]  pick;
  logic        relax;
  logic [31:0] plim;
  logic        plim_on;
  logic [31:0] ptgt;
  logic [31:0] ftgt;
  logic        pre_go;

  assign hs_en = ctrl_q[dpll_xient_pkg::ctrl_hs_en];
  assign pre_go = ref_valid && state_q == dpll_xient_pkg::st_acquire
                  && pick == 4'h8 && !rec_q && !pre_done_q
                  && ctrl_q[dpll_xient_pkg::ctrl_pre_en] && preacq_q != 16'h0;

  // Methods applicable in the current acquire or recover state
  always_comb begin
    app = fl_cfg_q[3:0] & (rec_q ? fl_cfg_q[7:4] : ~fl_cfg_q[7:4]);
    app = app & ~done_q;
    if (fl_cfg_q[1])
      app[2] = 1'b0;
    pick = 4'h0;
    if (app[0])
      pick = 4'h1;
    else if (app[1])
      pick = 4'h2;
    else if (app[2])
      pick = 4'h4;
    else if (app[3])
      pick = 4'h8;
  end

  // Slope limit in ps per ms tick equals the setting plus one, in ns/s
  always_comb begin
    relax   = bw_wide_q | bw_max_q;
    plim    = relax ? {16'h0, fl_psl_q} + 32'h1
                    : {16'h0, psl_q} + 32'h1;
    plim_on = relax | ctrl_q[dpll_xient_pkg::ctrl_psl_en];
    ptgt    = ol_on_q ? ol_tgt_q : phase_loop;
    ftgt    = clamp(snap_on_q ? snap_tgt_q : freq_loop,
                    max_freq_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end else if (pre_go) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 32'(tick_cycles - 1)) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q     <= 1'b0;
    end
  end

  // Channel state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q      <= dpll_xient_pkg::st_acquire;
      rec_q        <= 1'b0;
      done_q       <= 4'h0;
      pre_done_q   <= 1'b0;
      last_ref_q   <= 4'h0;
      snap_on_q    <= 1'b0;
      snap_tgt_q   <= 32'h0;
      ol_on_q      <= 1'b0;
      ol_tgt_q     <= 32'h0;
      ms_cnt_q     <= 16'h0;
      hs_count_q   <= 16'h0;
      phase_zero_q <= 32'h0;
      loop_open_q  <= 1'b0;
      bw_max_q     <= 1'b0;
      bw_wide_q    <= 1'b0;
    end else begin
      unique case (state_q)
        dpll_xient_pkg::st_acquire: begin
          if (!ref_valid) begin
            state_q <= dpll_xient_pkg::st_hold;
          end else if (pick == 4'h1) begin
            if (freq_meas_valid) begin
              snap_tgt_q <= freq_meas;
              snap_on_q  <= 1'b1;
              done_q[0]  <= 1'b1;
            end
          end else if (pick == 4'h2) begin
            if (phase_meas_valid)
              done_q[1] <= 1'b1;
          end else if (pick == 4'h4) begin
            loop_open_q <= 1'b1;
            if (phase_meas_valid) begin
              ol_tgt_q <= phase_meas;
              ol_on_q  <= 1'b1;
            end
            if (dpll_locked && ol_on_q) begin
              loop_open_q <= 1'b0;
              ol_on_q     <= 1'b0;
              done_q[2]   <= 1'b1;
            end
          end else if (pick == 4'h8) begin
            if (pre_go) begin
              state_q  <= dpll_xient_pkg::st_preacq;
              ms_cnt_q <= 16'h0;
              bw_max_q <= 1'b1;
            end else begin
              bw_wide_q <= 1'b1;
              if (dpll_locked) begin
                bw_wide_q <= 1'b0;
                done_q[3] <= 1'b1;
              end
            end
          end else if (dpll_locked) begin
            state_q    <= dpll_xient_pkg::st_locked;
            rec_q      <= 1'b1;
            snap_on_q  <= 1'b0;
            last_ref_q <= ref_sel;
          end
        end
        dpll_xient_pkg::st_preacq: begin
          if (tick_q)
            ms_cnt_q <= ms_cnt_q + 16'h1;
          if (!ref_valid || (tick_q && ms_cnt_q + 16'h1 >= preacq_q)) begin
            bw_max_q   <= 1'b0;
            pre_done_q <= 1'b1;
            state_q    <= ref_valid ? dpll_xient_pkg::st_acquire
                                    : dpll_xient_pkg::st_hold;
          end
        end
        dpll_xient_pkg::st_locked: begin
          if (!ref_valid) begin
            state_q <= dpll_xient_pkg::st_hold;
          end else if (ref_sel != last_ref_q) begin
            last_ref_q <= ref_sel;
            if (hs_en) begin
              state_q <= dpll_xient_pkg::st_hs_hold;
            end else begin
              state_q      <= dpll_xient_pkg::st_acquire;
              phase_zero_q <= 32'h0;
              done_q       <= 4'h0;
              pre_done_q   <= 1'b0;
            end
          end
        end
        dpll_xient_pkg::st_hold: begin
          loop_open_q <= 1'b0;
          bw_wide_q   <= 1'b0;
          ol_on_q     <= 1'b0;
          snap_on_q   <= 1'b0;
          if (ref_valid) begin
            last_ref_q <= ref_sel;
            done_q     <= 4'h0;
            pre_done_q <= 1'b0;
            if (hs_en && rec_q) begin
              state_q <= dpll_xient_pkg::st_hs_hold;
            end else begin
              state_q      <= dpll_xient_pkg::st_acquire;
              phase_zero_q <= 32'h0;
            end
          end
        end
        dpll_xient_pkg::st_hs_hold: begin
          if (!ref_valid) begin
            state_q <= dpll_xient_pkg::st_hold;
          end else if (phase_meas_valid) begin
            // Type 2 removes the nominal-frequency residual
            phase_zero_q <= ctrl_q[dpll_xient_pkg::ctrl_hs_type]
                            ? phase_meas - frac_residual
                            : phase_meas;
            hs_count_q   <= hs_count_q + 16'h1;
            state_q      <= dpll_xient_pkg::st_locked;
          end
        end
        default: state_q <= dpll_xient_pkg::st_hold;
      endcase
    end
  end

  // Output phase steering
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_cmd_q <= 32'h0;
    end else if (state_q == dpll_xient_pkg::st_acquire && pick == 4'h2
                 && phase_meas_valid) begin
      phase_cmd_q <= phase_meas;
    end else if (holdover_q) begin
      phase_cmd_q <= phase_cmd_q;
    end else if (!plim_on) begin
      phase_cmd_q <= ptgt;
    end else if (tick_q) begin
      phase_cmd_q <= step(phase_cmd_q, ptgt, plim);
    end
  end

  // Divider frequency word; only phase is compensated on a switch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_cmd_q <= 32'h0;
    end else if (holdover_q) begin
      freq_cmd_q <= clamp(freq_cmd_q, max_freq_q);
    end else if (snap_on_q && ctrl_q[dpll_xient_pkg::ctrl_fsl_en]) begin
      if (tick_q)
        freq_cmd_q <= step(freq_cmd_q, ftgt, fsl_q);
    end else begin
      freq_cmd_q <= ftgt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      holdover_q       <= 1'b0;
      holdover_alarm_q <= 1'b0;
      meas_req_q       <= 1'b0;
      revertive_q      <= 1'b0;
    end else begin
      holdover_q       <= state_q == dpll_xient_pkg::st_hold
                          || state_q == dpll_xient_pkg::st_hs_hold;
      holdover_alarm_q <= state_q == dpll_xient_pkg::st_hold;
      meas_req_q       <= state_q == dpll_xient_pkg::st_hs_hold
                          || (state_q == dpll_xient_pkg::st_acquire
                              && pick != 4'h0 && pick != 4'h8);
      revertive_q      <= ctrl_q[dpll_xient_pkg::ctrl_revert];
    end
  end

  // AXI4-Lite write path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_q          <= 8'h00;
      wd_q          <= 32'h0;
      ws_q          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_got_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_got_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        aw_q     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wd_q    <= s_axi_wdata;
        ws_q    <= s_axi_wstrb;
      end
      if (aw_got_q && w_got_q && !s_axi_bvalid) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (aw_q)
          dpll_xient_pkg::ctrl_off, dpll_xient_pkg::psl_off,
          dpll_xient_pkg::max_freq_off, dpll_xient_pkg::fl_cfg_off,
          dpll_xient_pkg::fl_psl_off, dpll_xient_pkg::fsl_off,
          dpll_xient_pkg::preacq_off: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= dpll_xient_pkg::ctrl_rst;
      psl_q      <= dpll_xient_pkg::psl_rst;
      max_freq_q <= dpll_xient_pkg::max_freq_rst;
      fl_cfg_q   <= dpll_xient_pkg::fl_cfg_rst;
      fl_psl_q   <= dpll_xient_pkg::fl_psl_rst;
      fsl_q      <= dpll_xient_pkg::fsl_rst;
      preacq_q   <= dpll_xient_pkg::preacq_rst;
    end else if (aw_got_q && w_got_q && !s_axi_bvalid) begin
      for (int i = 0; i < 4; i++) begin
        if (ws_q[i]) begin
          unique case (aw_q)
            dpll_xient_pkg::ctrl_off:     ctrl_q[i*8+:8] <= wd_q[i*8+:8];
            dpll_xient_pkg::max_freq_off: max_freq_q[i*8+:8] <= wd_q[i*8+:8];
            dpll_xient_pkg::fsl_off:      fsl_q[i*8+:8] <= wd_q[i*8+:8];
            default: ;
          endcase
          if (i < 2) begin
            unique case (aw_q)
              dpll_xient_pkg::psl_off:    psl_q[i*8+:8] <= wd_q[i*8+:8];
              dpll_xient_pkg::fl_psl_off: fl_psl_q[i*8+:8] <= wd_q[i*8+:8];
              dpll_xient_pkg::preacq_off: preacq_q[i*8+:8] <= wd_q[i*8+:8];
              default: ;
            endcase
          end
          if (i == 0 && aw_q == dpll_xient_pkg::fl_cfg_off)
            fl_cfg_q <= wd_q[7:0];
        end
      end
    end
  end

  // AXI4-Lite read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        unique case (s_axi_araddr)
          dpll_xient_pkg::ctrl_off:     s_axi_rdata <= ctrl_q;
          dpll_xient_pkg::psl_off:      s_axi_rdata <= {16'h0, psl_q};
          dpll_xient_pkg::max_freq_off: s_axi_rdata <= max_freq_q;
          dpll_xient_pkg::fl_cfg_off:   s_axi_rdata <= {24'h0, fl_cfg_q};
          dpll_xient_pkg::fl_psl_off:   s_axi_rdata <= {16'h0, fl_psl_q};
          dpll_xient_pkg::fsl_off:      s_axi_rdata <= fsl_q;
          dpll_xient_pkg::preacq_off:   s_axi_rdata <= {16'h0, preacq_q};
          dpll_xient_pkg::status_off:
            s_axi_rdata <= {hs_count_q, 4'h0, done_q, rec_q,
                            holdover_alarm_q, holdover_q, dpll_locked,
                            1'b0, state_q};
          dpll_xient_pkg::zero_off:     s_axi_rdata <= phase_zero_q;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ### tb/dpll_ref_model.sv
`timescale 1ns/1ps
module dpll_ref_model #(
  parameter int dly = 6
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Request and values to report
  input  wire logic        meas_req_q,
  input  wire logic [31:0] ph_val,
  input  wire logic [31:0] fr_val,
  // Measurement results
  output logic [31:0]      phase_meas,
  output logic             phase_meas_valid,
  output logic [31:0]      freq_meas,
  output logic             freq_meas_valid
);
  logic [7:0] cnt_q;
  logic       done_q;
  logic       fire;

  assign fire = aresetn && meas_req_q && !done_q && cnt_q == 8'(dly);

  // One answer for each request, after a measuring delay
  always_ff @(posedge aclk) begin
    if (!aresetn || !meas_req_q) begin
      cnt_q  <= 8'h00;
      done_q <= 1'b0;
    end else if (!done_q) begin
      cnt_q  <= cnt_q + 8'h01;
      done_q <= fire;
    end
  end

  // Data lines show a moving pattern outside the valid pulse
  always_ff @(posedge aclk) begin
    phase_meas_valid <= fire;
    freq_meas_valid  <= fire;
    phase_meas       <= fire ? ph_val : ~phase_meas;
    freq_meas        <= fire ? fr_val : ~freq_meas;
  end
endmodule

// ### tb/dpll_xient_sva.sv
`timescale 1ns/1ps
module dpll_xient_sva (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Loop side
  input wire logic        ref_valid,
  input wire logic        phase_meas_valid,
  input wire logic [31:0] phase_zero_q,
  input wire logic        loop_open_q,
  input wire logic        bw_max_q,
  input wire logic        bw_wide_q,
  input wire logic        holdover_q,
  input wire logic        holdover_alarm_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence zero_moved;
    $changed(phase_zero_q) && phase_zero_q != 32'h0;
  endsequence

  a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("no write response");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no read data");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_write_refuse: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  a_alarm_in_hold: assert property (holdover_alarm_q |-> holdover_q)
    else $error("alarm outside holdover");
  a_alarm_cause: assert property ($rose(holdover_alarm_q) |->
    !ref_valid || !$past(ref_valid)) else $error("alarm with valid ref");
  a_zero_cause: assert property (zero_moved |->
    $past(phase_meas_valid) || $past(phase_meas_valid, 2))
    else $error("zero point without measurement");
  a_fastlock_one: assert property (!(loop_open_q &&
    (bw_wide_q || bw_max_q))) else $error("two fast-lock methods");
endmodule

bind dpll_switch_transient_control dpll_xient_sva u_sva (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ref_valid,
  .phase_meas_valid, .phase_zero_q, .loop_open_q, .bw_max_q, .bw_wide_q,
  .holdover_q, .holdover_alarm_q);

// ### tb/dpll_switch_transient_control_bench.sv
`timescale 1ns/1ps
module dpll_switch_transient_control_bench;
  localparam int tk = 20;
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, ref_sel;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, ref_valid, dpll_locked, revertive_q;
  logic        phase_meas_valid, freq_meas_valid, loop_open_q, bw_max_q;
  logic        bw_wide_q, meas_req_q, holdover_q, holdover_alarm_q;
  logic [31:0] phase_meas, freq_meas, frac_residual, phase_loop, freq_loop;
  logic [31:0] phase_zero_q, phase_cmd_q, freq_cmd_q, ph_val, fr_val, rd;
  logic [31:0] rst_v [7] = '{32'h0, 32'h0, 32'h7fffffff, 32'h0, 32'hffff,
                             32'h1, 32'h0};
  logic [15:0] psl_v [5] = '{16'h0, 16'd884, 16'd7499, 16'd60999, 16'hffff};
  int          n_fail, checked, i, j;

  dpll_switch_transient_control #(.tick_cycles(tk)) dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ref_sel,
    .ref_valid, .dpll_locked, .phase_meas, .phase_meas_valid, .freq_meas,
    .freq_meas_valid, .frac_residual, .phase_loop, .freq_loop, .phase_zero_q,
    .phase_cmd_q, .loop_open_q, .bw_max_q, .bw_wide_q, .meas_req_q,
    .freq_cmd_q, .holdover_q, .holdover_alarm_q, .revertive_q);
  dpll_ref_model model (.aclk, .aresetn, .meas_req_q, .ph_val, .fr_val,
    .phase_meas, .phase_meas_valid, .freq_meas, .freq_meas_valid);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 400) begin
      chk(1'b0, "wait timed out");
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n);
    @(posedge aclk);
  endtask

  task automatic rd_t(input logic [7:0] a);
    int n;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
    @(posedge aclk);
  endtask

  task automatic reset_dut;
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, ref_sel, ref_valid, dpll_locked, frac_residual} = '0;
    {phase_loop, freq_loop, ph_val, fr_val} = '0;
    s_axi_wstrb = 4'hf;
    n_fail = 0;
    checked = 0;
    reset_dut();
    for (j = 0; j < 7; j++) begin
      rd_t(8'(j * 4));
      chk(rd === rst_v[j] && rs === 2'h0, "reset value");
    end
    chk(revertive_q === 1'b0, "revertive default");
    rd_t(8'h24);
    chk(rd === 32'h0 && rs === 2'h2, "unmapped read");
    wr(8'h1c, 32'h1);
    chk(rs === 2'h2, "status write");
    for (j = 0; j < 5; j++) begin
      wr(8'h04, {16'h0, psl_v[j]});
      rd_t(8'h04);
      chk(rd === {16'h0, psl_v[j]}, "slope readback");
    end
    wr(8'h00, 32'h20);
    chk(revertive_q === 1'b1, "revertive set");
    $display("test registers done");
    ref_valid   <= 1'b1;
    dpll_locked <= 1'b1;
    ph_val      <= 32'h1234;
    wr(8'h00, 32'h1);
    rd = '0;
    for (i = 0; i < 400 && rd[2:0] !== 3'h1; i++) rd_t(8'h1c);
    tmo(i);
    ref_sel <= 4'h1;
    for (i = 0; i < 400 && holdover_q !== 1'b1; i++) @(posedge aclk);
    tmo(i);
    chk(holdover_alarm_q === 1'b0, "alarm in switch");
    for (i = 0; i < 400 && holdover_q !== 1'b0; i++) @(posedge aclk);
    tmo(i);
    chk(phase_zero_q === 32'h1234, "zero point");
    phase_loop <= 32'h40;
    repeat (20) @(posedge aclk);
    chk(phase_zero_q === 32'h1234, "offset kept");
    $display("test hitless switch done");
    ref_valid <= 1'b0;
    for (i = 0; i < 400 && holdover_alarm_q !== 1'b1; i++) @(posedge aclk);
    tmo(i);
    chk(holdover_q === 1'b1, "real holdover");
    wr(8'h00, 32'h3);
    frac_residual <= 32'h34;
    ph_val        <= 32'h500;
    ref_valid     <= 1'b1;
    for (i = 0; i < 400 && holdover_q !== 1'b0; i++) @(posedge aclk);
    tmo(i);
    chk(phase_zero_q === 32'h4cc, "type 2 zero");
    chk(holdover_alarm_q === 1'b0, "alarm cleared");
    wr(8'h00, 32'h0);
    ref_sel <= 4'h2;
    for (i = 0; i < 400 && phase_zero_q !== 32'h0; i++) @(posedge aclk);
    tmo(i);
    chk(phase_zero_q === 32'h0, "disabled switch");
    $display("test holdover exit done");
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h4);
    phase_loop <= 32'h1000;
    repeat (5 * tk) @(posedge aclk);
    chk(phase_cmd_q > 32'h40 && phase_cmd_q <= 32'h46, "slope");
    wr(8'h00, 32'h0);
    for (i = 0; i < 400 && phase_cmd_q !== 32'h1000; i++) @(posedge aclk);
    tmo(i);
    wr(8'h08, 32'h100);
    freq_loop <= 32'h5000;
    for (i = 0; i < 400 && freq_cmd_q !== 32'h100; i++) @(posedge aclk);
    tmo(i);
    $display("test limits done");
    dpll_locked <= 1'b0;
    freq_loop   <= 32'h0;
    reset_dut();
    wr(8'h18, 32'h2);
    wr(8'h00, 32'h10);
    wr(8'h0c, 32'h08);
    for (i = 0; i < 400 && bw_max_q !== 1'b1; i++) @(posedge aclk);
    tmo(i);
    for (i = 0; i < 400 && bw_max_q === 1'b1; i++) @(posedge aclk);
    chk(i >= 2 * tk - 1 && i <= 2 * tk + 1, "pre-acq length");
    for (i = 0; i < 400 && bw_wide_q !== 1'b1; i++) @(posedge aclk);
    tmo(i);
    dpll_locked <= 1'b1;
    for (i = 0; i < 400 && bw_wide_q !== 1'b0; i++) @(posedge aclk);
    tmo(i);
    dpll_locked <= 1'b0;
    reset_dut();
    wr(8'h0c, 32'h06);
    for (i = 0; i < 60 && loop_open_q !== 1'b1; i++) @(posedge aclk);
    chk(i == 60, "pull-in with phase snap");
    wr(8'h0c, 32'h0c);
    for (i = 0; i < 400 && loop_open_q !== 1'b1; i++) @(posedge aclk);
    tmo(i);
    chk(bw_wide_q === 1'b0, "wide below pull-in");
    reset_dut();
    fr_val <= 32'h777;
    wr(8'h0c, 32'h01);
    for (i = 0; i < 400 && freq_cmd_q !== 32'h777; i++) @(posedge aclk);
    tmo(i);
    $display("test fast lock done");
    end_sim();
  end
endmodule
